// ---- design/lopcx_matrix.sv ----
`timescale 1ns/1ps
// Purpose: lower-order path connection matrix with one 1+1 protection group
// Assumes: every input stream runs on timingClockIn; mclk runs management
// Notes: table and selector state reach the stream through a toggle handshake

module lopcx_matrix #(
	parameter int NIN = 4,
	parameter int NOUT = 4,
	parameter int DW = 8,
	parameter bit SNC_EN = 1'b1,
	parameter int TICK_LEN = lopcx_pkg::TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic connReq,
	input wire logic discReq,
	input wire logic bridgeReq,
	input wire logic [$clog2(NIN)-1:0] connIn,
	input wire logic [$clog2(NOUT)-1:0] connOut,
	input wire logic [$clog2(NOUT)-1:0] bridgeOutCfg,
	input wire logic [lopcx_pkg::KIND_W-1:0] linkKindCfg,
	input wire logic [$clog2(NIN)-1:0] workInCfg,
	input wire logic [$clog2(NIN)-1:0] protInCfg,
	input wire logic [lopcx_pkg::KIND_W-1:0] protectionKindCfg,
	input wire logic revertModeCfg,
	input wire logic [lopcx_pkg::WTR_CFG_W-1:0] restoreWaitCfg,
	input wire logic [lopcx_pkg::HO_CFG_W-1:0] holdoffDelayCfg,
	input wire logic cmdStrobe,
	input wire logic [lopcx_pkg::CMD_W-1:0] operatorSwitchCommand,
	input wire logic [NIN-1:0] trailFailFlag,
	input wire logic [NIN-1:0] trailDegradeFlag,
	output logic selProtected,
	output logic wtrRunning,
	output logic cmdRejected,
	output logic cfgRejected,
	input wire logic timingClockIn,
	input wire logic timingFrameStartIn,
	input wire logic [NIN*DW-1:0] inData,
	input wire logic [NIN-1:0] inFs,
	input wire logic [NIN-1:0] connServerFailFlag,
	input wire logic outReady,
	output logic [NOUT*DW-1:0] outData,
	output logic [NOUT-1:0] outFs,
	output logic [NOUT-1:0] outServerFailFlag,
	output logic outValid,
	output logic upReady
);
	localparam int IW = $clog2(NIN);
	localparam int XW = 1 + 2 * NOUT + NOUT * IW + 2 * IW;
	localparam int SW = NOUT * (DW + 2);
	localparam int TW = $clog2(TICK_LEN);
	localparam int HOW = lopcx_pkg::HO_MS_W;
	localparam int WTW = lopcx_pkg::WTR_MS_W;

	generate
		if (NIN < 2 || NOUT < 2 || DW < 1 || TICK_LEN < 2) begin : gChk
			$error("lopcx_matrix: NIN, NOUT and TICK_LEN need at least 2");
		end
	endgenerate

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// defect source per kind
	function automatic logic pickFail(input logic [1:0] k, input logic [NIN-1:0] ssf,
			input logic [NIN-1:0] tsf, input logic [IW-1:0] i);
		return (k == lopcx_pkg::KIND_INHERENT) ? ssf[i] : tsf[i];
	endfunction

	function automatic logic pickDegrade(input logic [1:0] k, input logic [NIN-1:0] tsd,
			input logic [IW-1:0] i);
		return (k == lopcx_pkg::KIND_INHERENT) ? 1'b0 : tsd[i];
	endfunction

	function automatic logic cmdOk(input logic [2:0] c, input logic rev);
		case (c)
			lopcx_pkg::CMD_CLEAR,
			lopcx_pkg::CMD_LOCKOUT,
			lopcx_pkg::CMD_FORCED_PROT,
			lopcx_pkg::CMD_MANUAL_PROT: return 1'b1;
			lopcx_pkg::CMD_FORCED_WORK,
			lopcx_pkg::CMD_MANUAL_WORK: return !rev;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [HOW-1:0] holdoffMs(input logic [6:0] c);
		logic [HOW-1:0] s;
		s = (c > lopcx_pkg::HOLDOFF_MAX_STEPS) ? HOW'(lopcx_pkg::HOLDOFF_MAX_STEPS) : HOW'(c);
		return HOW'(s * lopcx_pkg::HOLDOFF_STEP_MS);
	endfunction

	function automatic logic [WTW-1:0] restoreMs(input logic [3:0] c);
		logic [WTW-1:0] m;
		m = WTW'(c);
		if (c < lopcx_pkg::WTR_MIN_MINUTES) begin
			m = WTW'(lopcx_pkg::WTR_MIN_MINUTES);
		end
		if (c > lopcx_pkg::WTR_MAX_MINUTES) begin
			m = WTW'(lopcx_pkg::WTR_MAX_MINUTES);
		end
		return WTW'(m * lopcx_pkg::MS_PER_MINUTE);
	endfunction

	// ----------------------------------------------------------------
	// connection table
	// ----------------------------------------------------------------
	logic [NOUT-1:0] mapUsed;
	logic [NOUT-1:0] mapProt;
	logic [IW-1:0] mapSrc [NOUT];
	logic [NOUT*IW-1:0] srcFlat;

	// protection only when the capability is built
	wire kindProt = SNC_EN && (linkKindCfg != lopcx_pkg::KIND_UNPROT);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mapUsed <= '0;
			mapProt <= '0;
			for (int i = 0; i < NOUT; i++) begin
				mapSrc[i] <= '0;
			end
		end else if (connReq) begin
			mapUsed[connOut] <= 1'b1;
			mapSrc[connOut] <= connIn;
			mapProt[connOut] <= kindProt;
		end else if (bridgeReq) begin
			mapUsed[connOut] <= 1'b1;
			mapSrc[connOut] <= connIn;
			mapProt[connOut] <= 1'b0;
			mapUsed[bridgeOutCfg] <= 1'b1;
			mapSrc[bridgeOutCfg] <= connIn;
			mapProt[bridgeOutCfg] <= 1'b0;
		end else if (discReq) begin
			mapUsed[connOut] <= 1'b0;
			mapProt[connOut] <= 1'b0;
		end
	end

	for (genvar o = 0; o < NOUT; o++) begin : gFlat
		assign srcFlat[o*IW +: IW] = mapSrc[o];
	end

	// ----------------------------------------------------------------
	// defects, timers and commands
	// ----------------------------------------------------------------
	logic [NIN-1:0] ssfM;
	logic [NIN-1:0] tsfM;
	logic [NIN-1:0] tsdM;
	logic ackM;
	logic ackT;
	logic [TW-1:0] tickCnt;
	logic tick;
	logic [HOW-1:0] hoCnt;
	logic [WTW-1:0] wtrCnt;
	logic [lopcx_pkg::CMD_W-1:0] cmdReg;
	lopcx_pkg::lopcx_state_type state;
	lopcx_pkg::lopcx_state_type next_state;

	// every defect and the ack toggle arrive from other domains
	lopcx_sync2 #(.W(3 * NIN + 1)) uSyncM (
		.clk(mclk),
		.rst(rst),
		.d({ackT, trailFailFlag, trailDegradeFlag, connServerFailFlag}),
		.q({ackM, tsfM, tsdM, ssfM})
	);

	wire sfW = pickFail(protectionKindCfg, ssfM, tsfM, workInCfg);
	wire sfP = pickFail(protectionKindCfg, ssfM, tsfM, protInCfg);
	wire sdW = pickDegrade(protectionKindCfg, tsdM, workInCfg);
	wire sdP = pickDegrade(protectionKindCfg, tsdM, protInCfg);
	wire rawW = sfW || sdW;
	wire [HOW-1:0] hoTarget = holdoffMs(holdoffDelayCfg);
	wire [WTW-1:0] wtrTarget = restoreMs(restoreWaitCfg);
	wire hoPass = rawW && (hoCnt >= hoTarget);
	wire sfWf = sfW && hoPass;
	wire sdWf = sdW && hoPass;
	wire wtrDone = wtrCnt >= wtrTarget;
	wire cmdGood = cmdOk(operatorSwitchCommand, revertModeCfg);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tickCnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (tickCnt == TW'(TICK_LEN - 1));
			tickCnt <= (tickCnt == TW'(TICK_LEN - 1)) ? '0 : tickCnt + 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hoCnt <= '0;
		end else if (!rawW) begin
			hoCnt <= '0;
		end else if (tick && (hoCnt < hoTarget)) begin
			hoCnt <= hoCnt + 1'b1;
		end
	end

	// wait-to-restore restarts on any working defect
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wtrCnt <= '0;
		end else if (state != lopcx_pkg::SEL_WAIT || rawW) begin
			wtrCnt <= '0;
		end else if (tick && !wtrDone) begin
			wtrCnt <= wtrCnt + 1'b1;
		end
	end

	// a refused command leaves the standing one in place
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmdReg <= lopcx_pkg::CMD_NONE;
			cmdRejected <= 1'b0;
		end else begin
			cmdRejected <= cmdStrobe && !cmdGood;
			if (cmdStrobe && cmdGood) begin
				cmdReg <= (operatorSwitchCommand == lopcx_pkg::CMD_CLEAR) ?
					lopcx_pkg::CMD_NONE : operatorSwitchCommand;
			end
		end
	end

	// ----------------------------------------------------------------
	// selector
	// ----------------------------------------------------------------
	// priority: lockout, protection fail, forced, fail, degrade, manual
	wire lockReq = !SNC_EN || (cmdReg == lopcx_pkg::CMD_LOCKOUT);
	wire forceP = cmdReg == lopcx_pkg::CMD_FORCED_PROT;
	wire forceW = cmdReg == lopcx_pkg::CMD_FORCED_WORK;
	wire manP = cmdReg == lopcx_pkg::CMD_MANUAL_PROT;
	wire manW = cmdReg == lopcx_pkg::CMD_MANUAL_WORK;
	wire degW = sdWf && !sdP;
	wire reqValid = lockReq || sfP || forceP || forceW || sfWf || degW || manP || manW;
	wire reqProt = lockReq ? 1'b0 : sfP ? 1'b0 : forceP ? 1'b1 : forceW ? 1'b0 :
		sfWf ? 1'b1 : degW ? 1'b1 : manP;

	always_comb begin
		next_state = state;
		case (state)
			lopcx_pkg::SEL_WORK: begin
				if (reqValid && reqProt) begin
					next_state = lopcx_pkg::SEL_PROT;
				end
			end
			lopcx_pkg::SEL_PROT: begin
				if (reqValid && !reqProt) begin
					next_state = lopcx_pkg::SEL_WORK;
				end else if (!reqValid && revertModeCfg) begin
					next_state = lopcx_pkg::SEL_WAIT;
				end
			end
			lopcx_pkg::SEL_WAIT: begin
				if (reqValid) begin
					next_state = reqProt ? lopcx_pkg::SEL_PROT : lopcx_pkg::SEL_WORK;
				end else if (!revertModeCfg) begin
					next_state = lopcx_pkg::SEL_PROT;
				end else if (wtrDone && !rawW) begin
					next_state = lopcx_pkg::SEL_WORK;
				end
			end
			default: next_state = lopcx_pkg::SEL_WORK;
		endcase
	end

	// decision is taken in the cycle after the condition
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= lopcx_pkg::SEL_WORK;
			selProtected <= 1'b0;
			wtrRunning <= 1'b0;
			cfgRejected <= 1'b0;
		end else begin
			state <= next_state;
			selProtected <= next_state != lopcx_pkg::SEL_WORK;
			wtrRunning <= next_state == lopcx_pkg::SEL_WAIT;
			cfgRejected <= (holdoffDelayCfg > lopcx_pkg::HOLDOFF_MAX_STEPS) ||
				(restoreWaitCfg < lopcx_pkg::WTR_MIN_MINUTES) ||
				(restoreWaitCfg > lopcx_pkg::WTR_MAX_MINUTES);
		end
	end

	// ----------------------------------------------------------------
	// crossing to the timing clock
	// ----------------------------------------------------------------
	logic reqT;
	logic reqL;
	logic [XW-1:0] xferWord;
	logic [XW-1:0] linkWord;
	wire selNow = state != lopcx_pkg::SEL_WORK;
	wire [XW-1:0] liveWord = {selNow, mapUsed, mapProt, srcFlat, workInCfg, protInCfg};
	wire xferIdle = reqT == ackM;

	// only changed entries alter the stream; the word is held until acked
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reqT <= 1'b0;
			xferWord <= '0;
		end else if (xferIdle && (xferWord != liveWord)) begin
			xferWord <= liveWord;
			reqT <= !reqT;
		end
	end

	lopcx_sync2 #(.W(1)) uSyncL (
		.clk(timingClockIn),
		.rst(rst),
		.d(reqT),
		.q(reqL)
	);

	always_ff @(posedge timingClockIn or posedge rst) begin
		if (rst) begin
			linkWord <= '0;
			ackT <= 1'b0;
		end else if (reqL != ackT) begin
			linkWord <= xferWord;
			ackT <= reqL;
		end
	end

	// ----------------------------------------------------------------
	// stream path
	// ----------------------------------------------------------------
	wire lSel = linkWord[XW-1];
	wire [NOUT-1:0] lUsed = linkWord[XW-2 -: NOUT];
	wire [NOUT-1:0] lProt = linkWord[XW-2-NOUT -: NOUT];
	wire [NOUT*IW-1:0] lSrc = linkWord[2*IW +: NOUT*IW];
	wire [IW-1:0] lWork = linkWord[IW +: IW];
	wire [IW-1:0] lProtIn = linkWord[0 +: IW];
	logic [NOUT*DW-1:0] xData;
	logic [NOUT-1:0] xFs;
	logic [NOUT-1:0] xSsf;
	logic [NOUT*DW-1:0] stData;
	logic [NOUT-1:0] stFs;
	logic [NOUT-1:0] stSsf;
	logic stValid;
	logic [SW-1:0] bufOut;

	for (genvar o = 0; o < NOUT; o++) begin : gCross
		wire [IW-1:0] src = lProt[o] ? (lSel ? lProtIn : lWork) : lSrc[o*IW +: IW];
		// unequipped fill on the timing frame start
		assign xData[o*DW +: DW] = lUsed[o] ? inData[src*DW +: DW] : {DW{lopcx_pkg::UNEQ_BIT}};
		assign xFs[o] = lUsed[o] ? inFs[src] : timingFrameStartIn;
		assign xSsf[o] = lUsed[o] && connServerFailFlag[src];
	end

	// a stall holds the stage, so nothing already inside the block is lost
	always_ff @(posedge timingClockIn or posedge rst) begin
		if (rst) begin
			stData <= '0;
			stFs <= '0;
			stSsf <= '0;
			stValid <= 1'b0;
		end else if (upReady) begin
			stData <= xData;
			stFs <= xFs;
			stSsf <= xSsf;
			stValid <= 1'b1;
		end
	end

	lopcx_skid #(.W(SW)) uBuf (
		.clk(timingClockIn),
		.rst(rst),
		.inValid(stValid),
		.inData({stData, stFs, stSsf}),
		.inReady(upReady),
		.outValid(outValid),
		.outData(bufOut),
		.outReady(outReady)
	);

	assign outData = bufOut[SW-1 -: NOUT*DW];
	assign outFs = bufOut[2*NOUT-1 -: NOUT];
	assign outServerFailFlag = bufOut[NOUT-1:0];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	for (genvar o = 0; o < NOUT; o++) begin : gUneq
		unequip_fill_a: assert property (
			@(posedge timingClockIn) disable iff (rst)
			(!lUsed[o] && upReady) |=> (stData[o*DW +: DW] == {DW{lopcx_pkg::UNEQ_BIT}} &&
				!stSsf[o] && stFs[o] == $past(timingFrameStartIn)))
			else $error("unconnected output is not unequipped");
	end

	conn_write_a: assert property (
		@(posedge mclk) disable iff (rst)
		(connReq && int'(connOut) < NOUT) |=>
			(mapUsed[$past(connOut)] && mapSrc[$past(connOut)] == $past(connIn)))
		else $error("connect request not stored");

	conn_kind_a: assert property (
		@(posedge mclk) disable iff (rst)
		(connReq && int'(connOut) < NOUT) |=> (mapProt[$past(connOut)] == $past(kindProt)))
		else $error("connection kind not stored");

	disc_clear_a: assert property (
		@(posedge mclk) disable iff (rst)
		(discReq && !connReq && !bridgeReq && int'(connOut) < NOUT) |=>
			!mapUsed[$past(connOut)])
		else $error("disconnect left the output fed");

	bridge_pair_a: assert property (
		@(posedge mclk) disable iff (rst)
		(bridgeReq && !connReq && int'(connOut) < NOUT && int'(bridgeOutCfg) < NOUT) |=>
			(mapUsed[$past(connOut)] && mapUsed[$past(bridgeOutCfg)] &&
			mapSrc[$past(connOut)] == mapSrc[$past(bridgeOutCfg)]))
		else $error("bridge does not feed both outputs");

	xfer_hold_a: assert property (
		@(posedge mclk) disable iff (rst)
		!xferIdle |=> $stable(xferWord))
		else $error("crossing word changed while in flight");

	lock_work_a: assert property (
		@(posedge mclk) disable iff (rst)
		(cmdReg == lopcx_pkg::CMD_LOCKOUT) |=> (state == lopcx_pkg::SEL_WORK))
		else $error("lockout did not hold working");

	cmd_refuse_a: assert property (
		@(posedge mclk) disable iff (rst)
		(cmdStrobe && revertModeCfg && (operatorSwitchCommand == lopcx_pkg::CMD_FORCED_WORK ||
			operatorSwitchCommand == lopcx_pkg::CMD_MANUAL_WORK)) |=>
			(cmdRejected && $stable(cmdReg)))
		else $error("revertive mode took a command to working");

	holdoff_wait_a: assert property (
		@(posedge mclk) disable iff (rst)
		(state == lopcx_pkg::SEL_WORK && cmdReg == lopcx_pkg::CMD_NONE && !hoPass) |=>
			(state == lopcx_pkg::SEL_WORK))
		else $error("switch before hold-off elapsed");

	fail_switch_a: assert property (
		@(posedge mclk) disable iff (rst)
		(SNC_EN && state == lopcx_pkg::SEL_WORK && cmdReg == lopcx_pkg::CMD_NONE &&
			sfWf && !sfP) |=> (state == lopcx_pkg::SEL_PROT && selProtected))
		else $error("working fail did not switch");

	wtr_return_a: assert property (
		@(posedge mclk) disable iff (rst)
		(state == lopcx_pkg::SEL_WAIT && revertModeCfg && wtrDone && !rawW && !reqValid) |=>
			(state == lopcx_pkg::SEL_WORK && !selProtected))
		else $error("no return to working after restore wait");

	nonrev_hold_a: assert property (
		@(posedge mclk) disable iff (rst)
		(state != lopcx_pkg::SEL_WORK && !revertModeCfg && !reqValid) |=>
			(state == lopcx_pkg::SEL_PROT))
		else $error("non-revertive selector left protection");

	wtr_range_a: assert property (
		@(posedge mclk) disable iff (rst)
		(restoreWaitCfg < lopcx_pkg::WTR_MIN_MINUTES ||
			restoreWaitCfg > lopcx_pkg::WTR_MAX_MINUTES) |=> cfgRejected)
		else $error("restore wait out of range not flagged");
endmodule // lopcx_matrix

// ---- include/lopcx_pkg.sv ----
// Purpose: shared constants and types of the lower-order path connection matrix
// Assumes: one protection group, byte-wide streams clocked by the timing clock
// Notes: times are kept in their own unit and turned into counts where counted

package lopcx_pkg;
	localparam int KIND_W = 2;
	localparam int CMD_W = 3;
	localparam int HO_CFG_W = 7;
	localparam int WTR_CFG_W = 4;
	localparam int HO_MS_W = 14;
	localparam int WTR_MS_W = 20;

	typedef enum logic [KIND_W-1:0] {
		KIND_UNPROT = 2'h0,
		KIND_INHERENT = 2'h1,
		KIND_NONINTRUSIVE = 2'h2,
		KIND_SUBLAYER = 2'h3
	} lopcx_kind_type;

	typedef enum logic [CMD_W-1:0] {
		CMD_NONE = 3'h0,
		CMD_CLEAR = 3'h1,
		CMD_LOCKOUT = 3'h2,
		CMD_FORCED_PROT = 3'h3,
		CMD_FORCED_WORK = 3'h4,
		CMD_MANUAL_PROT = 3'h5,
		CMD_MANUAL_WORK = 3'h6
	} lopcx_cmd_type;

	typedef enum logic [2:0] {
		SEL_WORK = 3'h1,
		SEL_PROT = 3'h2,
		SEL_WAIT = 3'h4
	} lopcx_state_type;

	localparam int MCLK_HZ = 125000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = MCLK_HZ / 1000 * TICK_MS;
	localparam int HOLDOFF_STEP_MS = 100;
	localparam int HOLDOFF_MAX_MS = 10000;
	localparam int HOLDOFF_MAX_STEPS = HOLDOFF_MAX_MS / HOLDOFF_STEP_MS;
	localparam int WTR_MIN_MINUTES = 5;
	localparam int WTR_MAX_MINUTES = 12;
	localparam int MS_PER_MINUTE = 60000;
	localparam int SWITCH_MAX_MS = 50;
	localparam int SWITCH_MAX_CYCLES = MCLK_HZ / 1000 * SWITCH_MAX_MS;
	localparam logic UNEQ_BIT = 1'h0;
	localparam logic STALL_RESET_READY = 1'h1;
endpackage

// ---- design/lopcx_sync2.sv ----
`timescale 1ns/1ps
// Purpose: two flip-flop level synchroniser
// Assumes: each bit is a level that stays put for several destination cycles
// Notes: bits are not coherent with each other; words need a handshake

module lopcx_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	generate
		if (W < 1) begin : gChk
			$error("lopcx_sync2: W must be at least 1");
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // lopcx_sync2

// ---- design/lopcx_skid.sv ----
`timescale 1ns/1ps
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: one clock domain
// Notes: outputs come straight from flip-flops; the spare entry absorbs a stall

module lopcx_skid #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	input wire logic [W-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [W-1:0] outData,
	input wire logic outReady
);
	logic [W-1:0] spare;
	wire take = inValid && inReady;
	wire drain = outReady || !outValid;

	generate
		if (W < 1) begin : gChk
			$error("lopcx_skid: W must be at least 1");
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			inReady <= lopcx_pkg::STALL_RESET_READY;
			outValid <= 1'b0;
			outData <= '0;
			spare <= '0;
		end else if (drain) begin
			if (!inReady) begin
				outData <= spare;
				outValid <= 1'b1;
				inReady <= 1'b1;
			end else begin
				outData <= inData;
				outValid <= take;
			end
		end else if (take) begin
			spare <= inData;
			inReady <= 1'b0;
		end
	end
endmodule // lopcx_skid

// ---- test/lopcx_far_end.sv ----
// Purpose: far-side model feeding the matrix inputs and draining its outputs
// Assumes: the equipment timing clock runs free, so streams never pause
// Notes: each input repeats one byte so a route shows as a steady copy
`timescale 1ns/1ps
module lopcx_far_end (
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] words,
	input wire logic [3:0] failSet,
	input wire logic stall,
	output logic [31:0] inData,
	output logic [3:0] inFs,
	output logic [3:0] serverFail,
	output logic frameStart,
	output logic outReady
);
	logic [2:0] phase;
	// ----
	// stream source and receiver
	// ----
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= 3'h0;
			inData <= 32'h0;
			inFs <= 4'h0;
			serverFail <= 4'h0;
			frameStart <= 1'h0;
			outReady <= 1'h0;
		end else begin
			phase <= phase + 3'h1;
			inData <= words;
			inFs <= {4{phase == 3'h7}};
			serverFail <= failSet;
			frameStart <= phase == 3'h7;
			outReady <= !stall;
		end
	end
endmodule // lopcx_far_end

// ---- test/lopcx_matrix_tb.sv ----
// Purpose: self-checking bench of the lower-order path matrix
// Assumes: short management tick; protection group on inputs 0 and 1
// Notes: a full wait-to-restore period is too long to run; only its start is seen
`timescale 1ns/1ps
module lopcx_matrix_tb;
	logic mclk = 1'h0, tclk = 1'h0, rst = 1'h1;
	logic connReq = 1'h0, discReq = 1'h0, bridgeReq = 1'h0, cmdStrobe = 1'h0;
	logic revertModeCfg = 1'h0, stall = 1'h0, watch = 1'h0, sel = 1'h0;
	logic [1:0] connIn = 2'h0, connOut = 2'h0, bridgeOutCfg = 2'h0, linkKindCfg = 2'h0;
	logic [1:0] workInCfg = 2'h0, protInCfg = 2'h1, protectionKindCfg = 2'h2;
	logic [3:0] restoreWaitCfg = 4'h5, tf = 4'h0, td = 4'h0, failSet = 4'h4, prot = 4'h0;
	logic [6:0] holdoffDelayCfg = 7'h00;
	logic [2:0] operatorSwitchCommand = 3'h0;
	logic [31:0] words = 32'h0, inData, outData;
	logic [3:0] inFs, serverFail, outFs, outServerFailFlag;
	logic selProtected, wtrRunning, cmdRejected, cfgRejected, outValid, upReady;
	logic timingFrameStartIn, outReady;
	int seed, failures = 0, nChecks = 0, cyc = 0, calm = 0;
	logic fs1 = 1'h0, fs2 = 1'h0;
	int route [4] = '{-1, -1, -1, -1};
	initial forever #4 mclk = ~mclk;
	initial begin
		#2;
		forever #6 tclk = ~tclk;
	end
	lopcx_matrix #(.TICK_LEN(4)) lopcx_matrix_i (.mclk(mclk), .rst(rst), .connReq(connReq),
		.discReq(discReq), .bridgeReq(bridgeReq), .connIn(connIn), .connOut(connOut),
		.bridgeOutCfg(bridgeOutCfg), .linkKindCfg(linkKindCfg), .workInCfg(workInCfg),
		.protInCfg(protInCfg), .protectionKindCfg(protectionKindCfg),
		.revertModeCfg(revertModeCfg), .restoreWaitCfg(restoreWaitCfg),
		.holdoffDelayCfg(holdoffDelayCfg), .cmdStrobe(cmdStrobe),
		.operatorSwitchCommand(operatorSwitchCommand), .trailFailFlag(tf),
		.trailDegradeFlag(td), .selProtected(selProtected), .wtrRunning(wtrRunning),
		.cmdRejected(cmdRejected), .cfgRejected(cfgRejected), .timingClockIn(tclk),
		.timingFrameStartIn(timingFrameStartIn), .inData(inData), .inFs(inFs),
		.connServerFailFlag(serverFail), .outReady(outReady), .outData(outData),
		.outFs(outFs), .outServerFailFlag(outServerFailFlag), .outValid(outValid),
		.upReady(upReady));
	lopcx_far_end lopcx_far_end_i (.clk(tclk), .rst(rst), .words(words), .failSet(failSet),
		.stall(stall), .inData(inData), .inFs(inFs), .serverFail(serverFail),
		.frameStart(timingFrameStartIn), .outReady(outReady));
	// ----
	// expectations and checks
	// ----
	function automatic logic [8:0] expOut(input int o);
		int i;
		i = prot[o] ? int'(sel) : route[o];
		return route[o] < 0 ? 9'h000 : {failSet[i], words[i*8+:8]};
	endfunction
	task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
		nChecks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkBit(input logic got, input logic exp);
		nChecks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic settle;
		repeat (60) @(negedge mclk);
	endtask
	task automatic checkAll;
		logic [8:0] e;
		settle;
		for (int o = 0; o < 4; o++) begin
			e = expOut(o);
			chkByte(outData[o*8+:8], e[7:0]);
			chkBit(outServerFailFlag[o], e[8]);
		end
		chkBit(outValid, 1'h1);
	endtask
	task automatic req(input int k, input logic [1:0] i, input logic [1:0] o,
		input logic [1:0] b);
		connIn = i;
		connOut = o;
		bridgeOutCfg = b;
		connReq = k == 0;
		bridgeReq = k == 1;
		discReq = k == 2;
		route[o] = k == 2 ? -1 : int'(i);
		prot[o] = k == 0 && linkKindCfg != 2'h0;
		if (k == 1) begin
			route[b] = int'(i);
			prot[b] = 1'h0;
		end
		@(negedge mclk);
		connReq = 1'h0;
		bridgeReq = 1'h0;
		discReq = 1'h0;
		@(negedge mclk);
	endtask
	task automatic cmd(input logic [2:0] c, input logic rj);
		logic seen;
		seen = 1'h0;
		operatorSwitchCommand = c;
		cmdStrobe = 1'h1;
		@(negedge mclk);
		seen = cmdRejected;
		cmdStrobe = 1'h0;
		repeat (3) begin
			@(negedge mclk);
			seen = seen | cmdRejected;
		end
		chkBit(seen, rj);
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", nChecks, failures);
		if (failures == 0 && nChecks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// an untouched output must never glitch while the table or timers change
	// frame start reaches every output two link edges later, once a stall has drained
	always @(negedge tclk) begin
		calm = stall ? 0 : calm + 1;
		if (watch && outValid) chkByte(outData[7:0], 8'(expOut(0)));
		if (watch && outValid && calm > 8) chkByte({4'h0, outFs}, {4'h0, {4{fs2}}});
		fs2 = fs1;
		fs1 = timingFrameStartIn;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			wrap_up;
		end
	end
	initial begin
		seed = 47;
		repeat (2) @(negedge mclk);
		rst = 1'h0;
		for (int i = 0; i < 4; i++) words[i*8+:8] = 8'($random(seed)) | 8'h01;
		checkAll;
		for (int o = 0; o < 3; o++) req(0, 2'($random(seed)), 2'(o), 2'h0);
		checkAll;
		watch = 1'h1;
		req(2, 2'h0, 2'h1, 2'h0);
		checkAll;
		req(1, 2'h2, 2'h1, 2'h3);
		holdoffDelayCfg = 7'h65;
		settle;
		chkBit(cfgRejected, 1'h1);
		holdoffDelayCfg = 7'h00;
		restoreWaitCfg = 4'h4;
		stall = 1'h1;
		settle;
		chkBit(cfgRejected, 1'h1);
		chkBit(upReady, 1'h0);
		restoreWaitCfg = 4'hc;
		stall = 1'h0;
		checkAll;
		chkBit(cfgRejected, 1'h0);
		// ----
		// protection group on output 2
		// ----
		protectionKindCfg = 2'h1;
		linkKindCfg = 2'h1;
		req(0, 2'h3, 2'h2, 2'h0);
		tf = 4'h1;
		checkAll;
		chkBit(selProtected, 1'h0);
		failSet = 4'h5;
		sel = 1'h1;
		checkAll;
		cmd(3'h4, 1'h0);
		sel = 1'h0;
		checkAll;
		protectionKindCfg = 2'h2;
		cmd(3'h1, 1'h0);
		settle;
		chkBit(selProtected, 1'h1);
		tf = 4'h0;
		settle;
		chkBit(selProtected, 1'h1);
		for (int m = 0; m < 2; m++) begin
			revertModeCfg = m[0];
			for (int c = 0; c < 7; c++) cmd(3'(c), c == 0 || (m == 1 && (c == 4 || c == 6)));
		end
		cmd(3'h1, 1'h0);
		tf = 4'h1;
		settle;
		tf = 4'h0;
		settle;
		chkBit(wtrRunning, 1'h1);
		chkBit(selProtected, 1'h1);
		protectionKindCfg = 2'h3;
		td = 4'h1;
		settle;
		chkBit(wtrRunning, 1'h0);
		chkBit(selProtected, 1'h1);
		wrap_up;
	end
endmodule // lopcx_matrix_tb
